// file: logic/enc_4b5b.sv
`timescale 1ns/100ps
module enc_4b5b (
  input wire logic [3:0] nibble, // data nibble
  output logic [4:0] code // matching data code-group
);

  always_comb begin
    case (nibble)
      4'h0: code = 5'h1e;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0a;
      4'h5: code = 5'h0b;
      4'h6: code = 5'h0e;
      4'h7: code = 5'h0f;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'ha: code = 5'h16;
      4'hb: code = 5'h17;
      4'hc: code = 5'h1a;
      4'hd: code = 5'h1b;
      4'he: code = 5'h1c;
      4'hf: code = 5'h1d;
      default: code = 5'h1e;
    endcase
  end

endmodule : enc_4b5b

// file: logic/nibble_fifo.sv
`timescale 1ns/100ps
module nibble_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  input wire logic wr_clk, // write side clock
  input wire logic wr_rst_n, // write side reset, active low
  input wire logic wr_valid, // word offered
  output logic wr_ready, // room for a word
  input wire logic [WIDTH-1:0] wr_data, // word written
  input wire logic rd_clk, // read side clock
  input wire logic rd_rst_n, // read side reset, active low
  output logic rd_valid, // word available
  input wire logic rd_ready, // word taken
  output logic [WIDTH-1:0] rd_data // oldest word
);

  localparam int AW = $clog2(DEPTH);

  // pointers carry one extra bit so full and empty differ; gray copies cross
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] rgray_s1;
    logic [AW:0] rgray_s2;
  } wside_type;

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] wgray_s1;
    logic [AW:0] wgray_s2;
  } rside_type;

  wside_type w_q, w_d;
  rside_type r_q, r_d;
  logic [AW:0] w_next;
  logic [AW:0] r_next;

  // full: write pointer a whole lap ahead of the synced read pointer
  assign wr_ready = (w_q.gray != {~w_q.rgray_s2[AW:AW-1], w_q.rgray_s2[AW-2:0]});
  assign rd_valid = (r_q.gray != r_q.wgray_s2);
  assign rd_data = w_q.mem[r_q.bin[AW-1:0]];

  always_comb begin
    w_d = w_q;
    w_next = w_q.bin + {{AW{1'b0}}, 1'b1};
    w_d.rgray_s1 = r_q.gray;
    w_d.rgray_s2 = w_q.rgray_s1;
    if (wr_valid && wr_ready) begin
      w_d.mem[w_q.bin[AW-1:0]] = wr_data;
      w_d.bin = w_next;
      w_d.gray = w_next ^ (w_next >> 1);
    end
  end

  always_comb begin
    r_d = r_q;
    r_next = r_q.bin + {{AW{1'b0}}, 1'b1};
    r_d.wgray_s1 = w_q.gray;
    r_d.wgray_s2 = r_q.wgray_s1;
    if (rd_valid && rd_ready) begin
      r_d.bin = r_next;
      r_d.gray = r_next ^ (r_next >> 1);
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule : nibble_fifo

// file: logic/tx_nibble_encoder.sv
`timescale 1ns/100ps
`include "txenc_params.svh"
module tx_nibble_encoder
  import txenc_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic CLK, // core clock, 100 MHz
  input wire logic RST_N, // asynchronous reset, active low
  input wire logic LINK_CLK, // transmit clock from the MAC side pins
  input wire logic RMII_SEL, // 1 selects 2-bit mode, 0 selects 4-bit mode
  input wire logic [3:0] TXD, // transmit data pins, low two used in 2-bit mode
  input wire logic TXEN, // transmit enable pin
  input wire logic TXER, // transmit error pin
  output logic TX_OVERRUN, // sticky: a nibble was lost on a full buffer
  output logic [4:0] CODE_GROUP, // code-group towards the scrambler
  output logic CODE_VALID, // code-group valid, high from the first edge after reset
  input wire logic CODE_READY // scrambler takes the code-group
);

  // link domain reset: asserts at once, releases on the link clock
  logic link_rst_s1_q;
  logic link_rst_n_q;

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_rst_s1_q <= 1'b0;
      link_rst_n_q <= 1'b0;
    end else begin
      link_rst_s1_q <= 1'b1;
      link_rst_n_q <= link_rst_s1_q;
    end
  end

  link_state_type lk_q, lk_d;
  logic fifo_wr_ready;
  logic err_rise;
  logic [`WORD_W-1:0] end_word;

  // the mac keeps data qualified by enable, so enable alone marks frame edges
  always_comb begin
    lk_d = lk_q;
    end_word = `WORD_END;
    lk_d.mode_s1 = RMII_SEL;
    lk_d.mode_s2 = lk_q.mode_s1;
    // pins sampled once on every rising link edge, in both modes
    lk_d.txd = TXD;
    lk_d.en = TXEN;
    lk_d.er = TXER;
    lk_d.en_prev = lk_q.en;
    lk_d.er_prev = lk_q.en ? lk_q.er : 1'b0;
    err_rise = lk_q.en && lk_q.er && !lk_q.er_prev;
    lk_d.push = 1'b0;
    // a word offered while the buffer is full is dropped and remembered
    if (lk_q.push && !fifo_wr_ready) begin
      lk_d.overrun = 1'b1;
    end
    if (lk_q.en) begin
      if (!lk_q.mode_s2) begin
        // one nibble per link cycle
        lk_d.push = 1'b1;
        lk_d.word = {1'b1, err_rise, lk_q.txd};
      end else if (!lk_q.phase) begin
        // first dibit is the low half of the nibble
        lk_d.phase = 1'b1;
        lk_d.low_dibit = lk_q.txd[1:0];
        lk_d.err_pend = err_rise;
      end else begin
        lk_d.phase = 1'b0;
        lk_d.push = 1'b1;
        lk_d.word = {1'b1, lk_q.err_pend | err_rise, lk_q.txd[1:0], lk_q.low_dibit};
        lk_d.err_pend = 1'b0;
      end
    end else begin
      // an odd dibit left at frame end is discarded
      lk_d.phase = 1'b0;
      lk_d.err_pend = 1'b0;
      if (lk_q.en_prev) begin
        lk_d.push = 1'b1;
        lk_d.word = end_word;
      end
    end
  end

  always_ff @(posedge LINK_CLK or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [`WORD_W-1:0] fifo_rd_data;
  logic [4:0] data_code;

  nibble_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .wr_clk(LINK_CLK),
    .wr_rst_n(link_rst_n_q),
    .wr_valid(lk_q.push),
    .wr_ready(fifo_wr_ready),
    .wr_data(lk_q.word),
    .rd_clk(CLK),
    .rd_rst_n(RST_N),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data)
  );

  // every data nibble becomes one code-group
  enc_4b5b u_enc (
    .nibble(fifo_rd_data[`WORD_NIB_HI:`WORD_NIB_LO]),
    .code(data_code)
  );

  core_state_type cr_q, cr_d;
  logic word_en;
  logic word_er;
  logic advance;

  assign word_en = fifo_rd_data[`WORD_EN];
  assign word_er = fifo_rd_data[`WORD_ER];
  assign advance = cr_q.valid && CODE_READY;

  // the scrambler paces us; a word is popped only as a code-group is loaded
  always_comb begin
    cr_d = cr_q;
    cr_d.valid = 1'b1;
    fifo_rd_ready = 1'b0;
    if (advance) begin
      case (cr_q.state)
        ST_IDLE: begin
          cr_d.code = `CG_IDLE;
          if (fifo_rd_valid) begin
            fifo_rd_ready = 1'b1;
            if (word_en) begin
              // first nibble of the frame is replaced by J
              cr_d.code = `CG_J;
              cr_d.state = ST_SEND_K;
            end
          end
        end
        ST_SEND_K: begin
          // buffer ran dry mid frame: flag it on the line rather than stall
          cr_d.code = `CG_H;
          if (fifo_rd_valid) begin
            fifo_rd_ready = 1'b1;
            if (word_en) begin
              cr_d.code = `CG_K;
              cr_d.state = ST_DATA;
            end else begin
              cr_d.code = `CG_T;
              cr_d.state = ST_SEND_R;
            end
          end
        end
        ST_DATA: begin
          cr_d.code = `CG_H;
          if (fifo_rd_valid) begin
            fifo_rd_ready = 1'b1;
            if (!word_en) begin
              cr_d.code = `CG_T;
              cr_d.state = ST_SEND_R;
            end else if (word_er) begin
              cr_d.code = `CG_H;
            end else begin
              cr_d.code = data_code;
            end
          end
        end
        ST_SEND_R: begin
          cr_d.code = `CG_R;
          cr_d.state = ST_IDLE;
        end
        default: begin
          cr_d.code = `CG_IDLE;
          cr_d.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cr_q.state <= ST_IDLE;
      cr_q.code <= `CG_IDLE;
      cr_q.valid <= 1'b0;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign CODE_GROUP = cr_q.code;
  assign CODE_VALID = cr_q.valid;
  assign TX_OVERRUN = lk_q.overrun;

endmodule : tx_nibble_encoder

// file: logic/txenc_params.svh
`ifndef TXENC_PARAMS_SVH
`define TXENC_PARAMS_SVH

// control code-groups
`define CG_IDLE 5'h1f
`define CG_J 5'h18
`define CG_K 5'h11
`define CG_T 5'h0d
`define CG_R 5'h07
`define CG_H 5'h04

// fifo word layout: {in_frame, err_rise, nibble[3:0]}
`define WORD_W 6
`define WORD_EN 5
`define WORD_ER 4
`define WORD_NIB_HI 3
`define WORD_NIB_LO 0
`define FIFO_DEPTH 4

// reset value and end-of-frame marker word
`define NIBBLE_RST 4'h0
`define WORD_END 6'h00

`endif

// file: logic/txenc_pkg.sv
package txenc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND_K,
    ST_DATA,
    ST_SEND_R
  } enc_state_type;

  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic [3:0] txd;
    logic en;
    logic er;
    logic en_prev;
    logic er_prev;
    logic phase;
    logic [1:0] low_dibit;
    logic err_pend;
    logic push;
    logic [5:0] word;
    logic overrun;
  } link_state_type;

  typedef struct packed {
    enc_state_type state;
    logic [4:0] code;
    logic valid;
  } core_state_type;

endpackage : txenc_pkg

// file: tb/mac_model.sv
`timescale 1ns/100ps
module mac_model (
  input wire logic lclk, // link clock
  input wire logic rmii, // 2-bit mode
  output logic [3:0] txd, // data pins
  output logic txen, // enable
  output logic txer // error
);
  initial begin
    txd = 4'h0;
    txen = 1'b0;
    txer = 1'b0;
  end
  task automatic send(input logic [31:0] nibs, input int n, input int er);
    logic [3:0] v;
    for (int i = 0; i < n; i++) begin
      v = nibs[4*i +: 4];
      for (int d = 0; d < (rmii ? 2 : 1); d++) begin
        @(negedge lclk);
        txen <= 1'b1;
        txer <= (i == er);
        // unused pins toggle so nothing leans on stale values
        txd <= rmii ? {~txd[3:2], (d == 1) ? v[3:2] : v[1:0]} : v;
      end
    end
    repeat (2) begin
      @(negedge lclk);
      txen <= 1'b0;
      txer <= 1'b0;
      txd <= ~txd;
    end
  endtask : send
endmodule : mac_model

// file: tb/tx_nibble_encoder_chk.sv
`timescale 1ns/100ps
module tx_nibble_encoder_chk (
  input wire logic CLK, // core clock
  input wire logic RST_N, // reset, active low
  input wire logic [4:0] CODE_GROUP, // code-group out
  input wire logic CODE_VALID, // group valid
  input wire logic CODE_READY // group taken
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic take;
  logic dat;
  assign take = CODE_VALID && CODE_READY;
  assign dat = CODE_GROUP inside {5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  property p_valid; $past(RST_N) |-> CODE_VALID; endproperty
  a_valid: assert property (p_valid) else $error("valid dropped");
  property p_hold; CODE_VALID && !CODE_READY |=> $stable(CODE_GROUP); endproperty
  a_hold: assert property (p_hold) else $error("group changed untaken");
  property p_legal; CODE_VALID |-> dat || CODE_GROUP inside {5'h1f, 5'h18, 5'h11, 5'h0d,
    5'h07, 5'h04}; endproperty
  a_legal: assert property (p_legal) else $error("bad code-group");
  property p_jk; take && CODE_GROUP == 5'h18 |=> CODE_GROUP == 5'h11; endproperty
  a_jk: assert property (p_jk) else $error("J not followed by K");
  property p_tr; take && CODE_GROUP == 5'h0d |=> CODE_GROUP == 5'h07; endproperty
  a_tr: assert property (p_tr) else $error("T not followed by R");
  property p_ri; take && CODE_GROUP == 5'h07 |=> CODE_GROUP == 5'h1f; endproperty
  a_ri: assert property (p_ri) else $error("no idle after R");
  property p_ij; take && CODE_GROUP == 5'h1f |=> CODE_GROUP inside {5'h1f, 5'h18}; endproperty
  a_ij: assert property (p_ij) else $error("idle left without J");
  property p_body;
    take && (dat || CODE_GROUP inside {5'h11, 5'h04}) |=> dat || CODE_GROUP inside {5'h04, 5'h0d};
  endproperty
  a_body: assert property (p_body) else $error("frame body broken");
  c_j: cover property (take && CODE_GROUP == 5'h18);
  c_h: cover property (take && CODE_GROUP == 5'h04);
  c_t: cover property (take && CODE_GROUP == 5'h0d);
endmodule : tx_nibble_encoder_chk

bind tx_nibble_encoder tx_nibble_encoder_chk u_chk (.CLK(CLK), .RST_N(RST_N),
  .CODE_GROUP(CODE_GROUP), .CODE_VALID(CODE_VALID), .CODE_READY(CODE_READY));

// file: tb/tx_nibble_encoder_test.sv
`timescale 1ns/100ps
module tx_nibble_encoder_test;
  // rows: data nibble beside the code-group that it must become
  localparam logic [8:0] ROW [16] = '{{4'h0, 5'h1e}, {4'h1, 5'h09}, {4'h2, 5'h14},
    {4'h3, 5'h15}, {4'h4, 5'h0a}, {4'h5, 5'h0b}, {4'h6, 5'h0e}, {4'h7, 5'h0f}, {4'h8, 5'h12},
    {4'h9, 5'h13}, {4'ha, 5'h16}, {4'hb, 5'h17}, {4'hc, 5'h1a}, {4'hd, 5'h1b}, {4'he, 5'h1c},
    {4'hf, 5'h1d}};
  logic clk, rst_n, lclk, rmii_sel, rdy, txen, txer, ovr, vld;
  logic [3:0] txd;
  logic [4:0] cg;
  logic [4:0] got [$];
  int n_mismatch, n_checks, per, cnt;
  tx_nibble_encoder #(.DEPTH(4)) u_dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(lclk),
    .RMII_SEL(rmii_sel), .TXD(txd), .TXEN(txen), .TXER(txer), .TX_OVERRUN(ovr),
    .CODE_GROUP(cg), .CODE_VALID(vld), .CODE_READY(rdy));
  mac_model u_mac (.lclk(lclk), .rmii(rmii_sel), .txd(txd), .txen(txen), .txer(txer));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end
  // consumer slower than the link, so the buffer never runs dry mid frame;
  // 4-bit frames stay at three nibbles so the end marker still finds room
  always @(negedge clk) begin
    cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
    rdy <= (per != 0) && (cnt == 0);
  end
  always @(posedge clk) if (rst_n && vld === 1'b1 && rdy && cg !== 5'h1f) got.push_back(cg);
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, seen, want);
    end
  endtask : check
  task report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic frame(input logic [15:0] nibs, input int n, input int er, input int p,
    input logic [9:0] m);
    logic [4:0] w [$];
    int t;
    w = '{5'h18, 5'h11};
    for (int i = 0; i < n - 2; i++) w.push_back(m[5*i +: 5]);
    w.push_back(5'h0d);
    w.push_back(5'h07);
    per = p;
    got.delete();
    u_mac.send({16'h0000, nibs}, n, er);
    t = 0;
    while (got.size() < w.size() && t < 300) begin
      @(posedge clk);
      t++;
    end
    repeat (20) @(posedge clk);
    check(8'(got.size()), 8'(w.size()));
    for (int i = 0; i < w.size() && i < got.size(); i++) check({3'h0, got[i]}, {3'h0, w[i]});
  endtask : frame
  initial begin
    rst_n = 1'b0;
    rmii_sel = 1'b0;
    rdy = 1'b0;
    per = 3;
    cnt = 0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (6) @(posedge lclk);
    for (int r = 0; r < 16; r++) begin
      frame({4'h0, ROW[r][8:5], 8'h55}, 3, 9, 3, {5'h00, ROW[r][4:0]});
    end
    frame({4'h0, 4'h3, 8'h55}, 3, 2, 3, 10'h004);
    @(negedge lclk) rmii_sel = 1'b1;
    repeat (6) @(posedge lclk);
    frame({4'h9, 4'hc, 8'h55}, 4, 9, 4, {ROW[9][4:0], ROW[12][4:0]});
    frame({4'h5, 4'h3, 8'h55}, 4, 2, 4, {ROW[5][4:0], 5'h04});
    @(negedge lclk) rmii_sel = 1'b0;
    repeat (6) @(posedge lclk);
    @(negedge clk) check({7'h00, ovr}, 8'h00);
    per = 0;
    u_mac.send(32'h76543210, 8, 9);
    repeat (10) @(posedge lclk);
    @(negedge clk) check({7'h00, ovr}, 8'h01);
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk) check({3'h0, cg}, 8'h1f);
    check({6'h00, vld, ovr}, 8'h00);
    rst_n = 1'b1;
    repeat (6) @(posedge lclk);
    frame({4'h0, 4'he, 8'h55}, 3, 9, 3, {5'h00, ROW[14][4:0]});
    report_and_stop;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule : tx_nibble_encoder_test
